// >>> lin_bus_node.sv
// far side of the lin pin: a pulled-up wire shared with one other node
// assumes the block's txd drives the wire and its rxd reads it back
`timescale 1ns/1ps
`default_nettype none

module lin_bus_node (
    input wire logic txd,
    input wire logic dominant,
    output logic rxd
);
    // wired-and: the other node may pull low over a recessive bit
    assign rxd = txd & ~dominant;
endmodule

`default_nettype wire

// >>> lin_interrupt_and_sync_control.sv
// lin event flags, enables, interrupt gating and baud synchronisation
// assumes all strobes and event inputs come from logic on ref_clk;
// only the rxd pin is asynchronous and is synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "lin_irq_consts.svh"

// How it works
// (R01) master enable gates every flag; when set each enabled flag interrupts
// (R02) software checks pending flags before changing the master enable
// (R03) bit error reaches the interrupt only while its enable is one
// (R04) auto sync flag sets after divisor loads from acquired rate
// (R05) break sent flag sets when a break transmission completes
// (R06) sync received flag sets on valid sync byte after a break; mode zero sets it with no break check
// (R07) counter overflow flag sets when lin counter reaches all ones
// (R08) sync received flag clears only by writing one to it
// (R09) mode zero accepts measured rate within six percent of setting
// (R10) mode one resyncs every frame, loading measured rate into divisor
// (R11) mode one accepts measured rate within fifty percent of setting
// (R12) mode one needs break under 32 bit times and 253952 clocks
// (R13) software selects mode one when auto or manual update is used
// (R14) in mode one sync valid status shows last sync success
// (R15) polarity bit inverts transmit; same position reads sync valid
// (R16) slave with auto update copies acquired rate and raises flag
// (R17) slave stores measured divisor on valid sync and raises event
// (R18) bit error flag sets when read back bit differs from sent bit
// (R19) other flags clear only by writing one; zero leaves them
// (R20) request is OR of flag AND enable, gated by master enable
module lin_interrupt_and_sync_control
    import lin_irq_pkg::*;
#(
    parameter int BREAK_MAX_CLK = `BREAK_MAX_CLOCKS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic rxd,
    input wire logic tx_bit,
    input wire logic tx_sample,
    input wire logic break_done,
    input wire logic break_active,
    input wire sync_meas_t sync_meas,
    input wire logic [15:0] lin_count,
    input wire logic rx_busy,
    input wire logic line_idle,
    output logic txd,
    output logic tx_abort,
    output logic rx_abort,
    output logic [15:0] baud_divisor,
    output logic [15:0] acquired_baud_divisor,
    output logic lin_irq
);

    localparam logic [20:0] BRK_CLK_LIM = 21'(BREAK_MAX_CLK);

    if (BREAK_MAX_CLK < 32'h00000001 || BREAK_MAX_CLK > 32'h001fffff) begin
        $error("BREAK_MAX_CLK out of range of the break counter");
    end

    lin_state_t st_ff;
    lin_state_t nxt_st;

    logic wr_flags;
    logic wr_enables;
    logic wr_ctl;
    logic wr_baud_hi;
    logic wr_baud_lo;
    logic bit_err_evt;
    logic ovf_evt;
    logic [15:0] diff;
    logic [23:0] diff_scaled;
    logic [23:0] baud_mode0;
    logic [23:0] baud_mode1;
    logic [20:0] brk_bits_lim;
    logic rate_ok;
    logic brk_ok;
    logic accept;
    logic auto_load;
    logic [7:0] flags_rd;
    logic [7:0] enables_rd;

    always_comb begin
        wr_flags = reg_req.wr && reg_req.addr == `ADDR_EVENT_FLAGS;
        wr_enables = reg_req.wr && reg_req.addr == `ADDR_EVENT_ENABLES;
        wr_ctl = reg_req.wr && reg_req.addr == `ADDR_SYNC_CONTROL;
        wr_baud_hi = reg_req.wr && reg_req.addr == `ADDR_ACQ_BAUD_HI;
        wr_baud_lo = reg_req.wr && reg_req.addr == `ADDR_ACQ_BAUD_LO;

        // compare what the bus shows with what was driven onto it
        bit_err_evt = tx_sample // see (R18)
            && (st_ff.rxd_sync != (tx_bit ^ st_ff.tx_polarity_invert));
        ovf_evt = (lin_count == `LIN_COUNT_FULL) // see (R07)
            && !st_ff.count_full_prev;

        // rate deviation against the current setting
        if (sync_meas.divisor >= st_ff.baud_divisor) begin
            diff = sync_meas.divisor - st_ff.baud_divisor;
        end else begin
            diff = st_ff.baud_divisor - sync_meas.divisor;
        end
        diff_scaled = {8'h00, diff} * `PCT_SCALE;
        baud_mode0 = {8'h00, st_ff.baud_divisor} * `MODE0_TOL_PCT;
        baud_mode1 = {8'h00, st_ff.baud_divisor} * `MODE1_TOL_PCT;
        brk_bits_lim = {st_ff.baud_divisor, 5'h00};

        if (st_ff.sync_mode_select) begin
            rate_ok = diff_scaled <= baud_mode1; // see (R11)
            brk_ok = (st_ff.break_len < brk_bits_lim)
                && (st_ff.break_len < BRK_CLK_LIM); // see (R12)
        end else begin
            rate_ok = diff_scaled <= baud_mode0; // see (R09)
            brk_ok = 1'b1;
        end
        accept = sync_meas.valid && st_ff.slave_mode && rate_ok && brk_ok;
        // mode one reloads on every accepted sync; otherwise only with auto update on
        auto_load = accept // see (R10) (R16)
            && (st_ff.sync_mode_select || st_ff.auto_sync_update_enable);

        flags_rd = '0;
        flags_rd[`FLG_RX_BUSY] = rx_busy;
        flags_rd[`FLG_BIT_ERROR] = st_ff.bit_error_flag;
        flags_rd[`FLG_LINE_STATE] = st_ff.rxd_sync;
        flags_rd[`FLG_LINE_IDLE] = line_idle;
        flags_rd[`FLG_AUTO_SYNC] = st_ff.auto_sync_update_flag;
        flags_rd[`FLG_BREAK_SENT] = st_ff.break_sent_flag;
        flags_rd[`FLG_SYNC_RX] = st_ff.sync_received_flag;
        flags_rd[`FLG_CNT_OVF] = st_ff.counter_overflow_flag;

        enables_rd = '0;
        enables_rd[`EN_MASTER] = st_ff.lin_master_irq_enable;
        enables_rd[`EN_BIT_ERROR] = st_ff.bit_error_irq_enable;
        enables_rd[`EN_SYNC_MODE] = st_ff.sync_mode_select;
        enables_rd[`EN_SYNC_VALID] = st_ff.sync_valid_status; // see (R15)
        enables_rd[`EN_AUTO_SYNC] = st_ff.auto_sync_update_irq_enable;
        enables_rd[`EN_BREAK_SENT] = st_ff.break_sent_irq_enable;
        enables_rd[`EN_SYNC_RX] = st_ff.sync_received_irq_enable;
        enables_rd[`EN_CNT_OVF] = st_ff.counter_overflow_irq_enable;
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tx_abort = 1'b0;
        nxt_st.rx_abort = 1'b0;
        nxt_st.rxd_meta = rxd;
        nxt_st.rxd_sync = st_ff.rxd_meta;
        nxt_st.txd = tx_bit ^ st_ff.tx_polarity_invert; // see (R15)
        nxt_st.count_full_prev = lin_count == `LIN_COUNT_FULL;
        nxt_st.break_prev = break_active;

        // break length, restarted at each break, saturating
        if (break_active && !st_ff.break_prev) begin
            nxt_st.break_len = 21'h000001;
        end else if (break_active && st_ff.break_len != 21'h1fffff) begin
            nxt_st.break_len = st_ff.break_len + 21'h000001;
        end

        // software writes; write one clears a flag
        if (wr_flags) begin
            if (reg_req.wdata[`FLG_BIT_ERROR]) begin
                nxt_st.bit_error_flag = 1'b0;
            end
            if (reg_req.wdata[`FLG_AUTO_SYNC]) begin
                nxt_st.auto_sync_update_flag = 1'b0; // see (R19)
            end
            if (reg_req.wdata[`FLG_BREAK_SENT]) begin
                nxt_st.break_sent_flag = 1'b0; // see (R19)
            end
            if (reg_req.wdata[`FLG_SYNC_RX]) begin
                nxt_st.sync_received_flag = 1'b0; // see (R08)
            end
            if (reg_req.wdata[`FLG_CNT_OVF]) begin
                nxt_st.counter_overflow_flag = 1'b0; // see (R19)
            end
            nxt_st.force_clr_tx = reg_req.wdata[`FLG_FORCE_CLR_TX];
            nxt_st.force_clr_rx = reg_req.wdata[`FLG_FORCE_CLR_RX];
        end
        if (wr_enables) begin
            nxt_st.lin_master_irq_enable = reg_req.wdata[`EN_MASTER];
            nxt_st.bit_error_irq_enable = reg_req.wdata[`EN_BIT_ERROR];
            nxt_st.sync_mode_select = reg_req.wdata[`EN_SYNC_MODE];
            nxt_st.tx_polarity_invert = reg_req.wdata[`EN_TX_POLARITY];
            nxt_st.auto_sync_update_irq_enable = reg_req.wdata[`EN_AUTO_SYNC];
            nxt_st.break_sent_irq_enable = reg_req.wdata[`EN_BREAK_SENT];
            nxt_st.sync_received_irq_enable = reg_req.wdata[`EN_SYNC_RX];
            nxt_st.counter_overflow_irq_enable = reg_req.wdata[`EN_CNT_OVF];
        end
        if (wr_ctl) begin
            nxt_st.auto_sync_update_enable = reg_req.wdata[`CTL_AUTO_SYNC_EN];
            nxt_st.slave_mode = reg_req.wdata[`CTL_SLAVE_MODE];
            if (reg_req.wdata[`CTL_MANUAL_UPDATE]) begin
                nxt_st.baud_divisor = st_ff.acquired_baud_divisor;
            end
        end
        if (wr_baud_hi) begin
            nxt_st.baud_divisor[15:8] = reg_req.wdata;
        end
        if (wr_baud_lo) begin
            nxt_st.baud_divisor[7:0] = reg_req.wdata;
        end

        // hardware events, applied last so a set beats a clear
        if (bit_err_evt) begin
            nxt_st.bit_error_flag = 1'b1; // see (R18)
            nxt_st.tx_abort = st_ff.force_clr_tx;
            nxt_st.rx_abort = st_ff.force_clr_rx;
        end
        if (break_done) begin
            nxt_st.break_sent_flag = 1'b1; // see (R05)
        end
        if (ovf_evt) begin
            nxt_st.counter_overflow_flag = 1'b1; // see (R07)
        end
        if (accept) begin
            nxt_st.acquired_baud_divisor = sync_meas.divisor; // see (R17)
            nxt_st.sync_received_flag = 1'b1; // see (R06) (R17)
        end
        if (auto_load) begin
            nxt_st.baud_divisor = sync_meas.divisor; // see (R10) (R16)
            nxt_st.auto_sync_update_flag = 1'b1; // see (R04) (R16)
        end
        if (sync_meas.valid && st_ff.slave_mode
            && st_ff.sync_mode_select) begin
            nxt_st.sync_valid_status = accept; // see (R14)
        end

        // read data stand in the cycle after the strobe only
        nxt_st.rdata = 8'h00;
        if (reg_req.rd) begin
            case (reg_req.addr)
                `ADDR_ACQ_BAUD_HI: begin
                    nxt_st.rdata = st_ff.acquired_baud_divisor[15:8];
                end
                `ADDR_ACQ_BAUD_LO: begin
                    nxt_st.rdata = st_ff.acquired_baud_divisor[7:0];
                end
                `ADDR_EVENT_FLAGS: nxt_st.rdata = flags_rd;
                `ADDR_EVENT_ENABLES: nxt_st.rdata = enables_rd;
                `ADDR_SYNC_CONTROL: begin
                    nxt_st.rdata[`CTL_AUTO_SYNC_EN] =
                        st_ff.auto_sync_update_enable;
                    nxt_st.rdata[`CTL_SLAVE_MODE] = st_ff.slave_mode;
                end
                default: nxt_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.rxd_meta <= 1'b1;
            st_ff.rxd_sync <= 1'b1;
            st_ff.txd <= 1'b1;
            st_ff.baud_divisor <= `RST_BAUD;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign txd = st_ff.txd;
    assign tx_abort = st_ff.tx_abort;
    assign rx_abort = st_ff.rx_abort;
    assign baud_divisor = st_ff.baud_divisor;
    assign acquired_baud_divisor = st_ff.acquired_baud_divisor;
    // see (R01) (R03) (R20)
    assign lin_irq = st_ff.lin_master_irq_enable && (
        (st_ff.bit_error_flag && st_ff.bit_error_irq_enable)
        || (st_ff.auto_sync_update_flag && st_ff.auto_sync_update_irq_enable)
        || (st_ff.break_sent_flag && st_ff.break_sent_irq_enable)
        || (st_ff.sync_received_flag && st_ff.sync_received_irq_enable)
        || (st_ff.counter_overflow_flag
            && st_ff.counter_overflow_irq_enable));

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_master_gate_off: assert property ( // see (R01)
        wr_enables && !reg_req.wdata[`EN_MASTER] |=> !lin_irq)
        else $error("interrupt raised while master enable clear");

    a_bit_err_masked: assert property ( // see (R03)
        wr_enables && reg_req.wdata == 8'h80 |=> !lin_irq)
        else $error("masked flag raised interrupt");

    a_auto_sync_set: assert property ( // see (R04)
        auto_load |=> st_ff.auto_sync_update_flag
        && st_ff.baud_divisor == $past(sync_meas.divisor))
        else $error("auto sync did not load divisor and set flag");

    a_break_sent_set: assert property ( // see (R05)
        break_done |=> st_ff.break_sent_flag)
        else $error("break sent flag not set");

    a_sync_rx_set: assert property ( // see (R06)
        accept |=> st_ff.sync_received_flag
        && st_ff.acquired_baud_divisor == $past(sync_meas.divisor))
        else $error("valid sync not recorded");

    a_cnt_ovf_set: assert property ( // see (R07)
        lin_count == `LIN_COUNT_FULL && !st_ff.count_full_prev
        |=> st_ff.counter_overflow_flag)
        else $error("counter overflow flag not set");

    a_sync_rx_hold: assert property ( // see (R08)
        st_ff.sync_received_flag && !(wr_flags
        && reg_req.wdata[`FLG_SYNC_RX]) |=> st_ff.sync_received_flag)
        else $error("sync received flag dropped without write one");

    a_mode1_break: assert property ( // see (R12)
        st_ff.sync_mode_select && st_ff.break_len >= BRK_CLK_LIM
        |-> !accept)
        else $error("sync accepted after overlong break");

    a_sync_valid_upd: assert property ( // see (R14)
        sync_meas.valid && st_ff.slave_mode && st_ff.sync_mode_select
        |=> st_ff.sync_valid_status == $past(accept))
        else $error("sync valid status not updated");

    a_tx_polarity: assert property ( // see (R15)
        ##1 txd == ($past(tx_bit) ^ $past(st_ff.tx_polarity_invert)))
        else $error("transmit polarity wrong");

    a_bit_err_set: assert property ( // see (R18)
        bit_err_evt |=> st_ff.bit_error_flag)
        else $error("bit error flag not set");

    a_flag_zero_keep: assert property ( // see (R19)
        wr_flags && reg_req.wdata == 8'h00 && st_ff.break_sent_flag
        |=> st_ff.break_sent_flag)
        else $error("write of zero cleared a flag");

    a_irq_hold: assert property ( // see (R20)
        lin_irq && !reg_req.wr && !$changed(st_ff.lin_master_irq_enable)
        |=> lin_irq)
        else $error("interrupt dropped without software action");

endmodule

`default_nettype wire

// >>> lin_interrupt_and_sync_control_tb_top.sv
// self-checking bench of the lin event, enable and sync control block
// assumes the package, its constants header and the bus node model
`timescale 1ns/1ps
`default_nettype none
`include "lin_irq_consts.svh"

module lin_interrupt_and_sync_control_tb_top;
    import lin_irq_pkg::*;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    reg_req_t reg_req = '0;
    logic [7:0] reg_rdata;
    logic rxd;
    logic tx_bit = 1'b1;
    logic tx_sample = 1'b0;
    logic break_done = 1'b0;
    logic break_active = 1'b0;
    logic dominant = 1'b0;
    logic rx_busy = 1'b0;
    logic line_idle = 1'b1;
    sync_meas_t sync_meas = '0;
    logic [15:0] lin_count = 16'h0000;
    logic txd, tx_abort, rx_abort, lin_irq;
    logic [15:0] baud_divisor, acquired_baud_divisor;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;

    always #10 ref_clk = ~ref_clk;

    lin_interrupt_and_sync_control #(.BREAK_MAX_CLK(300)) i_dut (
        .ref_clk(ref_clk), .rst(rst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .rxd(rxd), .tx_bit(tx_bit),
        .tx_sample(tx_sample), .break_done(break_done),
        .break_active(break_active), .sync_meas(sync_meas),
        .lin_count(lin_count), .rx_busy(rx_busy), .line_idle(line_idle),
        .txd(txd), .tx_abort(tx_abort), .rx_abort(rx_abort),
        .baud_divisor(baud_divisor),
        .acquired_baud_divisor(acquired_baud_divisor), .lin_irq(lin_irq)
    );

    lin_bus_node i_bus (.txd(txd), .dominant(dominant), .rxd(rxd));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            $display("Error timeout expected finish seen hang");
            give_verdict();
        end
    end

    task automatic chk_val(string what, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(string what, logic exp, logic got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic settle();
        @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge ref_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        reg_req.wr <= 1'b0;
    endtask

    task automatic rd(logic [15:0] a, logic [7:0] exp);
        @(posedge ref_clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        reg_req.rd <= 1'b0;
        #1;
        chk_val($sformatf("read %h", a), {8'h00, exp}, {8'h00, reg_rdata});
    endtask

    // one event pulse of the kind held in flag bit b
    task automatic fire(int b);
        @(posedge ref_clk);
        if (b == 6) begin
            dominant <= 1'b1;
            repeat (3) @(posedge ref_clk);
            tx_sample <= 1'b1;
        end else if (b == 2) begin
            break_done <= 1'b1;
        end else begin
            lin_count <= `LIN_COUNT_FULL;
        end
        @(posedge ref_clk);
        tx_sample <= 1'b0;
        break_done <= 1'b0;
        lin_count <= 16'h0000;
        dominant <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic sync_frame(int brk, logic [15:0] d);
        @(posedge ref_clk);
        if (brk > 0) begin
            break_active <= 1'b1;
            repeat (brk) @(posedge ref_clk);
            break_active <= 1'b0;
        end
        sync_meas <= '{valid: 1'b1, divisor: d};
        @(posedge ref_clk);
        sync_meas.valid <= 1'b0;
        settle();
    endtask

    task automatic t_reset();
        chk_val("baud", 16'h0000, baud_divisor);
        chk_val("acquired", 16'h0000, acquired_baud_divisor);
        rd(`ADDR_EVENT_FLAGS, 8'h30);
        rd(`ADDR_EVENT_ENABLES, 8'h00);
        rd(16'h1234, 8'h00);
        @(posedge ref_clk);
        rx_busy <= 1'b1;
        line_idle <= 1'b0;
        rd(`ADDR_EVENT_FLAGS, 8'ha0);
        @(posedge ref_clk);
        rx_busy <= 1'b0;
        line_idle <= 1'b1;
    endtask

    task automatic t_polarity();
        wr(`ADDR_EVENT_ENABLES, 8'h10);
        settle();
        chk_bit("txd", 1'b0, txd);
        rd(`ADDR_EVENT_ENABLES, 8'h00);
        wr(`ADDR_EVENT_ENABLES, 8'h00);
        settle();
        chk_bit("txd", 1'b1, txd);
    endtask

    task automatic ev_test(int b);
        logic [7:0] m;
        m = 8'h01 << b;
        fire(b);
        rd(`ADDR_EVENT_FLAGS, 8'h30 | m);
        chk_bit("irq", 1'b0, lin_irq);
        wr(`ADDR_EVENT_ENABLES, m);
        settle();
        chk_bit("irq", 1'b0, lin_irq);
        wr(`ADDR_EVENT_ENABLES, 8'h80 | m);
        settle();
        chk_bit("irq", 1'b1, lin_irq);
        wr(`ADDR_EVENT_ENABLES, 8'h80);
        settle();
        chk_bit("irq", 1'b0, lin_irq);
        wr(`ADDR_EVENT_FLAGS, 8'h00);
        rd(`ADDR_EVENT_FLAGS, 8'h30 | m);
        wr(`ADDR_EVENT_FLAGS, m);
        rd(`ADDR_EVENT_FLAGS, 8'h30);
        wr(`ADDR_EVENT_ENABLES, 8'h00);
    endtask

    // bit error with force-clear enables taken from bits 5 and 4 of v
    task automatic t_abort(logic [7:0] v);
        wr(`ADDR_EVENT_FLAGS, v);
        @(posedge ref_clk);
        dominant <= 1'b1;
        repeat (3) @(posedge ref_clk);
        tx_sample <= 1'b1;
        @(posedge ref_clk);
        tx_sample <= 1'b0;
        dominant <= 1'b0;
        #1;
        chk_bit("tx_abort", v[5], tx_abort);
        chk_bit("rx_abort", v[4], rx_abort);
        settle();
        chk_bit("tx_abort end", 1'b0, tx_abort);
        chk_bit("rx_abort end", 1'b0, rx_abort);
        wr(`ADDR_EVENT_FLAGS, 8'h40);
    endtask

    task automatic t_sync_mode0();
        wr(`ADDR_SYNC_CONTROL, 8'h04);
        wr(`ADDR_ACQ_BAUD_HI, 8'h00);
        wr(`ADDR_ACQ_BAUD_LO, 8'h64);
        settle();
        chk_val("baud", 16'h0064, baud_divisor);
        sync_frame(0, 16'h006a);
        chk_val("acquired", 16'h006a, acquired_baud_divisor);
        chk_val("baud", 16'h0064, baud_divisor);
        rd(`ADDR_EVENT_FLAGS, 8'h32);
        rd(`ADDR_ACQ_BAUD_LO, 8'h6a);
        wr(`ADDR_EVENT_FLAGS, 8'h00);
        rd(`ADDR_EVENT_FLAGS, 8'h32);
        wr(`ADDR_EVENT_FLAGS, 8'h02);
        rd(`ADDR_EVENT_FLAGS, 8'h30);
        sync_frame(0, 16'h006b);
        chk_val("acquired", 16'h006a, acquired_baud_divisor);
        rd(`ADDR_EVENT_FLAGS, 8'h30);
        // manual update copies the acquired rate, bit reads back zero
        wr(`ADDR_SYNC_CONTROL, 8'h06);
        settle();
        chk_val("manual baud", 16'h006a, baud_divisor);
        rd(`ADDR_SYNC_CONTROL, 8'h04);
    endtask

    task automatic t_sync_mode1();
        wr(`ADDR_SYNC_CONTROL, 8'h05);
        rd(`ADDR_EVENT_FLAGS, 8'h30);
        wr(`ADDR_EVENT_ENABLES, 8'haa);
        sync_frame(20, 16'h0096);
        chk_val("baud", 16'h0096, baud_divisor);
        chk_val("acquired", 16'h0096, acquired_baud_divisor);
        chk_bit("irq", 1'b1, lin_irq);
        rd(`ADDR_EVENT_FLAGS, 8'h3a);
        rd(`ADDR_EVENT_ENABLES, 8'hba);
        wr(`ADDR_EVENT_FLAGS, 8'h0a);
        settle();
        chk_bit("irq", 1'b0, lin_irq);
        sync_frame(20, 16'h00e2);
        chk_val("baud", 16'h0096, baud_divisor);
        rd(`ADDR_EVENT_ENABLES, 8'haa);
        sync_frame(20, 16'h00e1);
        chk_val("baud", 16'h00e1, baud_divisor);
    endtask

    task automatic t_break_limits();
        sync_frame(310, 16'h00e1);
        rd(`ADDR_EVENT_ENABLES, 8'haa);
        sync_frame(290, 16'h00e1);
        rd(`ADDR_EVENT_ENABLES, 8'hba);
        wr(`ADDR_ACQ_BAUD_HI, 8'h00);
        wr(`ADDR_ACQ_BAUD_LO, 8'h05);
        sync_frame(170, 16'h0005);
        rd(`ADDR_EVENT_ENABLES, 8'haa);
        sync_frame(150, 16'h0005);
        rd(`ADDR_EVENT_ENABLES, 8'hba);
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        #1;
        chk_bit("txd in reset", 1'b1, txd);
        chk_bit("irq in reset", 1'b0, lin_irq);
        @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_polarity();
        ev_test(0);
        ev_test(2);
        ev_test(6);
        t_abort(8'h10);
        t_abort(8'h20);
        t_sync_mode0();
        t_sync_mode1();
        t_break_limits();
        give_verdict();
    end
endmodule

`default_nettype wire

// >>> lin_irq_consts.svh
// constants of the lin event, enable and baud sync control block
// assumes inclusion by bare name from the package and the module
`ifndef LIN_IRQ_CONSTS_SVH
`define LIN_IRQ_CONSTS_SVH

// register byte addresses
`define ADDR_ACQ_BAUD_HI 16'ha093
`define ADDR_ACQ_BAUD_LO 16'ha094
`define ADDR_EVENT_FLAGS 16'ha095
`define ADDR_EVENT_ENABLES 16'ha096
`define ADDR_SYNC_CONTROL 16'ha0a0

// lin_event_flags fields
`define FLG_RX_BUSY 7
`define FLG_BIT_ERROR 6
`define FLG_LINE_STATE 5
`define FLG_FORCE_CLR_TX 5
`define FLG_LINE_IDLE 4
`define FLG_FORCE_CLR_RX 4
`define FLG_AUTO_SYNC 3
`define FLG_BREAK_SENT 2
`define FLG_SYNC_RX 1
`define FLG_CNT_OVF 0

// lin_event_enables fields
`define EN_MASTER 7
`define EN_BIT_ERROR 6
`define EN_SYNC_MODE 5
`define EN_SYNC_VALID 4
`define EN_TX_POLARITY 4
`define EN_AUTO_SYNC 3
`define EN_BREAK_SENT 2
`define EN_SYNC_RX 1
`define EN_CNT_OVF 0

// lin_sync_control fields
`define CTL_AUTO_SYNC_EN 0
`define CTL_MANUAL_UPDATE 1
`define CTL_SLAVE_MODE 2

// reset values
`define RST_EVENT_FLAGS 8'h00
`define RST_EVENT_ENABLES 8'h00
`define RST_BAUD 16'h0000

// sync acceptance figures
`define MODE0_TOL_PCT 24'h000006
`define MODE1_TOL_PCT 24'h000032
`define PCT_SCALE 24'h000064
`define BREAK_MAX_BITS 6'h20
`define BREAK_MAX_CLOCKS 32'h0003e000
`define LIN_COUNT_FULL 16'hffff

`endif

// >>> lin_irq_pkg.sv
// types of the lin event, enable and baud sync control block
// assumes the constants header sits in the same folder
package lin_irq_pkg;
    `include "lin_irq_consts.svh"

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] divisor;
    } sync_meas_t;

    typedef struct packed {
        logic rxd_meta;
        logic rxd_sync;
        logic bit_error_flag;
        logic auto_sync_update_flag;
        logic break_sent_flag;
        logic sync_received_flag;
        logic counter_overflow_flag;
        logic force_clr_tx;
        logic force_clr_rx;
        logic lin_master_irq_enable;
        logic bit_error_irq_enable;
        logic sync_mode_select;
        logic tx_polarity_invert;
        logic auto_sync_update_irq_enable;
        logic break_sent_irq_enable;
        logic sync_received_irq_enable;
        logic counter_overflow_irq_enable;
        logic sync_valid_status;
        logic auto_sync_update_enable;
        logic slave_mode;
        logic [15:0] baud_divisor;
        logic [15:0] acquired_baud_divisor;
        logic [20:0] break_len;
        logic break_prev;
        logic count_full_prev;
        logic txd;
        logic tx_abort;
        logic rx_abort;
        logic [7:0] rdata;
    } lin_state_t;
endpackage
